// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import sysctl_pkg::*;

   logic clk_sys_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0, beat = 0;
   logic fiq = 0, irq = 0, e, wb_ack_o, wb_err_o, strap = 1;
   logic [7:0] adr = 0;
   logic [3:0] sel = 4'hf;
   logic [31:0] wdat = 0, wb_dat_o, r;
   integer seed = 32'ha860;
   logic [2:0] req = 0, g, bus_grant_o;
   logic [11:0] rst_v;
   logic [15:0] da;
   logic [9:0] db;
   logic [10:0] dc;
   pwm_route_s [3:0] pwm_route_o;
   pin_ctrl_s pin_ctrl_o;
   logic [31:0] exp_q[$];
   logic [7:0] ofs [8] = '{OFS_SOFT_RESET, OFS_ARB_CTRL, OFS_PWM_ROUTE,
      OFS_PIN_ENABLE, OFS_USB_DET, OFS_DRIVE_A, OFS_DRIVE_B, OFS_DRIVE_C};
   logic [31:0] msk [8] = '{MASK_SOFT_RESET, MASK_ARB_CTRL, 32'hffff_ffff,
      MASK_PIN_ENABLE, MASK_USB_DET, MASK_DRIVE_A, MASK_DRIVE_B, MASK_DRIVE_C};
   int error_cnt = 0, total_checks = 0, cyc_cnt = 0;

   system_global_control u_system_global_control (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .debug_strap_i(strap),
      .ext_fiq_i(fiq), .ext_irq_i(irq), .bus_req_i(req), .bus_beat_i(beat),
      .bus_grant_o(bus_grant_o), .spi_slave_block_reset_o(rst_v[11]),
      .adc_reset_o(rst_v[10]), .gpio_reset_o(rst_v[9]),
      .sram_reset_o(rst_v[8]), .audio_unit_reset_o(rst_v[7]),
      .usb_device_block_reset_o(rst_v[6]), .spi_flash_ctrl_reset_o(rst_v[5]),
      .i2c_reset_o(rst_v[4]), .pwm_reset_o(rst_v[3]),
      .timer_watchdog_reset_o(rst_v[2]), .serial_port1_reset_o(rst_v[1]),
      .serial_port0_reset_o(rst_v[0]), .pwm_route_o(pwm_route_o),
      .pin_ctrl_o(pin_ctrl_o), .port_a_drive_bits_o(da),
      .port_b_drive_bits_o(db), .port_c_drive_bits_o(dc));

   always #5 clk_sys_i = ~clk_sys_i;

   // ------------------------------------------------------------
   // Checking
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] ex, input logic [31:0] act);
      total_checks++;
      if (act !== ex) begin
         error_cnt++;
         $display("mismatch t=%0t exp=%h act=%h", $time, ex, act);
      end
   endtask : chk

   task automatic results;
      if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results

   // Read data is judged at the ack edge, against the oldest note
   always @(posedge clk_sys_i) begin
      if (wb_ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         chk(exp_q.pop_front(), wb_dat_o);
      end
   end

   // Ceiling well above the few hundred cycles the run needs
   always @(posedge clk_sys_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         error_cnt++;
         results();
      end
   end

   // ------------------------------------------------------------
   // Wishbone classic master
   // ------------------------------------------------------------
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s = 4'hf);
      @(posedge clk_sys_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do @(posedge clk_sys_i);
      while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      e = wb_err_o;
      cyc <= 0;
      stb <= 0;
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      exp_q.push_back(x);
      wb(1'b0, a, 32'h0000_0000);
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
   endtask : settle

   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_n_i <= 1;
      for (int i = 0; i < 8; i++) begin
         r = (i == 3) ? 32'hffff_ffeb : 32'hffff_ffff;
         rd(ofs[i], (i == 3) ? 32'h0000_0001 : 32'h0000_0000);
         wb(1'b1, ofs[i], r);
         rd(ofs[i], msk[i] & r);
         wb(1'b1, ofs[i], 32'h0000_0000);
      end
      wb(1'b1, 8'h44, 32'hffff_ffff);
      chk(32'(e), 32'h0000_0001);
      r = $random(seed);
      wb(1'b1, OFS_SOFT_RESET, r);
      settle(0);
      chk(32'(rst_v), 32'({r[30], r[28], r[27], r[25], r[16], r[11], r[10],
          r[9], r[8], r[5], r[1], r[0]}));
      wb(1'b1, OFS_SOFT_RESET, 32'h0000_0000);
      settle(0);
      chk(32'(rst_v), 32'h0000_0000);
      for (int c = 0; c < 16; c++) begin
         wb(1'b1, OFS_USB_DET, 32'(c));
         settle(0);
         chk(32'({pin_ctrl_o.usb_detect_source_select,
             pin_ctrl_o.usb_detect_valid}),
             32'({4'(c), 1'(c != 0 && c != 13 && c != 15)}));
      end
      r = $random(seed);
      wb(1'b1, OFS_PWM_ROUTE, r);
      settle(0);
      for (int t = 0; t < 4; t++) begin
         chk(32'(pwm_route_o[t]), {23'h0, r[8*t+5 +: 3],
             r[8*t+5 +: 3] <= 3'h4, r[8*t +: 5]});
      end
      r = $random(seed) & 32'hffff_ffeb;
      wb(1'b1, OFS_PIN_ENABLE, r);
      settle(0);
      chk(32'(pin_ctrl_o), {8'h0, r[23:16], r[12], r[11], r[9], r[8], r[6],
          r[5], r[4:3], r[2:1], r[0], 4'hf, 1'b0});
      r = $random(seed);
      wb(1'b1, OFS_DRIVE_A, r);
      wb(1'b1, OFS_DRIVE_B, r);
      wb(1'b1, OFS_DRIVE_C, r);
      settle(0);
      chk(32'({dc, db, da}), 32'({r[10:0], r[9:0], r[15:0]}));
      wb(1'b1, OFS_DRIVE_A, 32'h0000_0000, 4'h2);
      rd(OFS_DRIVE_A, {24'h0, r[7:0]});
      for (int k = 0; k < 2; k++) begin
         wb(1'b1, OFS_ARB_CTRL, 32'h0000_0010);
         {fiq, irq} <= k ? 2'b10 : 2'b01;
         settle(3);
         // Requests rise once boost is active: boost does not preempt an owner before its burst ends
         @(posedge clk_sys_i) req <= 3'b111;
         settle(2);
         chk(32'(bus_grant_o), 32'h0000_0001);
         rd(OFS_ARB_CTRL, 32'h0000_0030);
         {fiq, irq} <= 2'b00;
         req <= 3'b000;
         settle(4);
         wb(1'b1, OFS_ARB_CTRL, 32'h0000_0030);
         rd(OFS_ARB_CTRL, 32'h0000_0010);
      end
      for (int m = 0; m < 2; m++) begin
         wb(1'b1, OFS_ARB_CTRL, 32'(m));
         req <= 3'b111;
         settle(3);
         g = bus_grant_o;
         if (m == 0) chk(32'(g), 32'h0000_0004);
         repeat (16) @(posedge clk_sys_i) beat <= 1;
         @(posedge clk_sys_i) beat <= 0;
         settle(3);
         chk(32'(bus_grant_o), 32'(m ? {g[0], g[2:1]} : 3'b100));
         @(posedge clk_sys_i) req <= 3'b000;
         settle(3);
      end
      wb(1'b1, OFS_ARB_CTRL, 32'h0000_0000);
      req <= 3'b011;
      settle(3);
      chk(32'(bus_grant_o), 32'h0000_0002);
      // Second reset in mid-run, this time with the strap low
      @(posedge clk_sys_i);
      strap <= 1'b0;
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(OFS_PIN_ENABLE, 32'h0000_0000);
      rd(OFS_ARB_CTRL, 32'h0000_0000);
      settle(0);
      results();
   end
endmodule : tb_top

`default_nettype wire

// [rtl/bus_arbiter.sv]
`timescale 1ns/1ps
`default_nettype none

module bus_arbiter (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Control
   input wire logic round_robin_i,
   input wire logic cpu_boost_i,
   // Masters: 0 cpu, 1 flash spi, 2 audio
   input wire logic [2:0] req_i,
   input wire logic beat_i,
   output logic [2:0] grant_o
);
   import sysctl_pkg::*;

   logic [2:0] grant_q;
   logic [2:0] grant_d;
   logic [1:0] rr_last_q;
   logic [4:0] beats_q;
   logic burst_end;
   logic [2:0] pick;

   assign burst_end = (beats_q == BURST_MAX - 5'd1) && beat_i;

   // Pick the next owner
   always_comb begin
      pick = 3'b000;
      if (cpu_boost_i && req_i[0]) begin
         pick = 3'b001;
      end else if (!round_robin_i) begin
         if (req_i[2]) begin
            pick = 3'b100;
         end else if (req_i[1]) begin
            pick = 3'b010;
         end else if (req_i[0]) begin
            pick = 3'b001;
         end
      end else begin
         // Last granted drops to lowest priority
         unique case (rr_last_q)
            2'd2: pick = req_i[1] ? 3'b010 : req_i[0] ? 3'b001 :
                         req_i[2] ? 3'b100 : 3'b000;
            2'd1: pick = req_i[0] ? 3'b001 : req_i[2] ? 3'b100 :
                         req_i[1] ? 3'b010 : 3'b000;
            default: pick = req_i[2] ? 3'b100 : req_i[1] ? 3'b010 :
                            req_i[0] ? 3'b001 : 3'b000;
         endcase
      end
   end

   // Owner keeps the bus until it drops the request or the burst ends
   always_comb begin
      if (grant_q != 3'b000 && (grant_q & req_i) != 3'b000 && !burst_end) begin
         grant_d = grant_q;
      end else begin
         grant_d = pick;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         grant_q <= 3'b000;
         rr_last_q <= 2'd0;
      end else begin
         grant_q <= grant_d;
         if (grant_d != grant_q && grant_d != 3'b000) begin
            rr_last_q <= grant_d[2] ? 2'd2 : grant_d[1] ? 2'd1 : 2'd0;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         beats_q <= 5'd0;
      end else if (grant_d != grant_q || burst_end) begin
         beats_q <= 5'd0;
      end else if (beat_i) begin
         beats_q <= beats_q + 5'd1;
      end
   end

   assign grant_o = grant_q;

   // Fixed mode or boost may hand the bus straight back to its owner
   AST_BURST_BREAK: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      burst_end && round_robin_i && !cpu_boost_i
      && (req_i & ~grant_q) != 3'b000 |=> grant_o != $past(grant_o))
      else $error("burst limit did not break ownership");
   AST_ONE_HOT: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i) $onehot0(grant_o))
      else $error("more than one grant");

endmodule : bus_arbiter

`default_nettype wire

// [rtl/pwm_route_decode.sv]
`timescale 1ns/1ps
`default_nettype none

module pwm_route_decode (
   // Raw field
   input wire logic [7:0] field_i,
   // Decoded routing
   output sysctl_pkg::pwm_route_s route_o
);
   import sysctl_pkg::*;

   // Codes above the last candidate leave the timer input unconnected
   always_comb begin
      route_o.input_route = field_i[7:5];
      route_o.input_valid = (field_i[7:5] <= PWM_IN_LAST);
      route_o.output_enables = field_i[4:0];
   end

endmodule : pwm_route_decode

`default_nettype wire

// [rtl/sysctl_pkg.sv]
package sysctl_pkg;

   // -------------------------------------------------------------
   // Register offsets (byte addresses)
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_SOFT_RESET = 8'h14;
   localparam logic [7:0] OFS_ARB_CTRL = 8'h20;
   localparam logic [7:0] OFS_PWM_ROUTE = 8'h30;
   localparam logic [7:0] OFS_PIN_ENABLE = 8'h34;
   localparam logic [7:0] OFS_USB_DET = 8'h38;
   localparam logic [7:0] OFS_DRIVE_A = 8'h74;
   localparam logic [7:0] OFS_DRIVE_B = 8'h78;
   localparam logic [7:0] OFS_DRIVE_C = 8'h7c;

   // -------------------------------------------------------------
   // Writable masks and reset values
   // -------------------------------------------------------------
   localparam logic [31:0] MASK_SOFT_RESET = 32'h5a01_0f23;
   localparam logic [31:0] MASK_ARB_CTRL = 32'h0000_0011;
   localparam logic [31:0] MASK_PIN_ENABLE = 32'h00ff_1b7f;
   localparam logic [31:0] MASK_USB_DET = 32'h0000_000f;
   localparam logic [31:0] MASK_DRIVE_A = 32'h0000_ffff;
   localparam logic [31:0] MASK_DRIVE_B = 32'h0000_03ff;
   localparam logic [31:0] MASK_DRIVE_C = 32'h0000_07ff;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int RST_SPI_SLAVE = 30;
   localparam int RST_ADC = 28;
   localparam int RST_GPIO = 27;
   localparam int RST_SRAM = 25;
   localparam int RST_AUDIO = 16;
   localparam int RST_USB = 11;
   localparam int RST_FLASH_SPI = 10;
   localparam int RST_I2C = 9;
   localparam int RST_PWM = 8;
   localparam int RST_TIMER = 5;
   localparam int RST_SERIAL1 = 1;
   localparam int RST_SERIAL0 = 0;
   localparam int ARB_MODE_BIT = 0;
   localparam int ARB_BOOST_EN_BIT = 4;
   localparam int ARB_BOOST_ACT_BIT = 5;
   localparam int PWM_FIELD_W = 8;
   localparam int PWM_IN_LSB = 5;
   localparam int PIN_ANALOG_LSB = 16;
   localparam int PIN_SER1_MODEM = 12;
   localparam int PIN_SER0_MODEM = 11;
   localparam int PIN_SER1_DATA = 9;
   localparam int PIN_SER0_DATA = 8;
   localparam int PIN_FLASH_SPI = 6;
   localparam int PIN_SPI_MS = 5;
   localparam int PIN_SPI2_LSB = 3;
   localparam int PIN_I2C_LSB = 1;
   localparam int PIN_DEBUG = 0;

   // -------------------------------------------------------------
   // Codes and arbiter constants
   // -------------------------------------------------------------
   localparam logic [2:0] PWM_IN_LAST = 3'h4;
   localparam logic [3:0] USB_DET_GAP = 4'hd;
   localparam logic [3:0] USB_DET_OFF = 4'hf;
   localparam logic [4:0] BURST_MAX = 5'h10;
   localparam int NUM_MASTERS = 3;

   // Owner code: 0 none, 1 cpu, 2 flash spi, 3 audio
   typedef enum logic [1:0] {
      OWN_NONE = 2'b00,
      OWN_CPU = 2'b01,
      OWN_FLASH = 2'b10,
      OWN_AUDIO = 2'b11
   } owner_e;

   typedef struct packed {
      logic [2:0] input_route;
      logic input_valid;
      logic [4:0] output_enables;
   } pwm_route_s;

   typedef struct packed {
      logic [7:0] analog_pin_enables;
      logic serial1_modem_pin_enable;
      logic serial0_modem_pin_enable;
      logic serial1_data_pin_enable;
      logic serial0_data_pin_enable;
      logic flash_spi_pin_enable;
      logic spi_master_slave_pin_enable;
      logic [1:0] second_spi_pin_location;
      logic [1:0] two_wire_pin_location;
      logic debug_port_pin_enable;
      logic [3:0] usb_detect_source_select;
      logic usb_detect_valid;
   } pin_ctrl_s;

endpackage : sysctl_pkg

// [rtl/system_global_control.sv]
// Operation
// - Soft-reset bit one holds peripheral in reset; flash SPIs share one bit.
// - Timer reset bit 5, serial port resets bits 1 and 0.
// - Arbitration mode bit 0: zero fixed, one round-robin.
// - Fixed priority: audio, then flash SPI, then CPU.
// - Boost enable bit 4 gives CPU highest priority during interrupts.
// - Active bit 5 set by boosted interrupt; write one clears.
// - 3-bit timer input route; codes above 100 disable the input.
// - Timer input fields at 31:29, 23:21, 15:13, 7:5.
// - 5-bit output enables per timer, each pin independent.
// - Eight analog pin enable bits hand port-A pins to converter.
// - Two modem pin enables route serial CTS/RTS pins.
// - Two data pin enables route serial TX/RX pins.
// - Bit 6 flash SPI pins, bit 5 SPI master/slave pins.
// - Second SPI location field; software never writes 11.
// - Two-wire location field; software never writes 11.
// - Bit 0 of pin register switches five pins to debug port.
// - USB detect select routes a pin; 0000 and 1111 disable.
// - Port A drive bits 15:0 choose per-pin drive level.
// - Port B bits 9:0 and port C bits 10:0 choose drive.
// - Round-robin demotes the granted master to lowest priority.
// - Active bit only set by hardware; software write never sets it.
// - Ownership broken when transfer count reaches sixteen; fixed mode or boost may re-grant the same owner.
`timescale 1ns/1ps
`default_nettype none

module system_global_control (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Power-on strap for the debug pins
   input wire logic debug_strap_i,
   // Interrupt lines (asynchronous pins, active high here)
   input wire logic ext_fiq_i,
   input wire logic ext_irq_i,
   // Bus masters: 0 cpu, 1 flash spi, 2 audio
   input wire logic [2:0] bus_req_i,
   input wire logic bus_beat_i,
   output logic [2:0] bus_grant_o,
   // Peripheral resets
   output logic spi_slave_block_reset_o,
   output logic adc_reset_o,
   output logic gpio_reset_o,
   output logic sram_reset_o,
   output logic audio_unit_reset_o,
   output logic usb_device_block_reset_o,
   output logic spi_flash_ctrl_reset_o,
   output logic i2c_reset_o,
   output logic pwm_reset_o,
   output logic timer_watchdog_reset_o,
   output logic serial_port1_reset_o,
   output logic serial_port0_reset_o,
   // Pin routing
   output sysctl_pkg::pwm_route_s [3:0] pwm_route_o,
   output sysctl_pkg::pin_ctrl_s pin_ctrl_o,
   output logic [15:0] port_a_drive_bits_o,
   output logic [9:0] port_b_drive_bits_o,
   output logic [10:0] port_c_drive_bits_o
);
   import sysctl_pkg::*;

   // -------------------------------------------------------------
   // Register storage
   // -------------------------------------------------------------
   logic [31:0] soft_reset_q;
   logic [31:0] arb_ctrl_q;
   logic [31:0] pwm_route_q;
   logic [31:0] pin_enable_q;
   logic [31:0] usb_det_q;
   logic [31:0] drive_a_q;
   logic [31:0] drive_b_q;
   logic [31:0] drive_c_q;
   logic ack_q;
   logic err_q;
   logic [31:0] rdata_q;
   logic strap_done_q;
   logic strap_meta_q;
   logic strap_sync_q;
   logic [1:0] irq_meta_q;
   logic [1:0] irq_sync_q;
   logic [31:0] wmask;
   logic req;
   logic wr;
   logic hit;
   logic irq_active;
   logic boost_set;
   logic boost_clr;
   logic [31:0] rdata_d;
   logic [3:0] det;

   // Requests taken only while no ack is outstanding
   assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
   assign wr = req && wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] mask);
      merge = ((old & ~wmask) | (wb_dat_i & wmask)) & mask;
   endfunction : merge

   // -------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------
   always_comb begin
      hit = 1'b1;
      rdata_d = 32'h0000_0000;
      unique case (wb_adr_i)
         OFS_SOFT_RESET: rdata_d = soft_reset_q;
         OFS_ARB_CTRL: rdata_d = arb_ctrl_q;
         OFS_PWM_ROUTE: rdata_d = pwm_route_q;
         OFS_PIN_ENABLE: rdata_d = pin_enable_q;
         OFS_USB_DET: rdata_d = usb_det_q;
         OFS_DRIVE_A: rdata_d = drive_a_q;
         OFS_DRIVE_B: rdata_d = drive_b_q;
         OFS_DRIVE_C: rdata_d = drive_c_q;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= RESET_VALUE;
      end else begin
         ack_q <= req && hit;
         err_q <= req && !hit;
         if (req && !wb_we_i && hit) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
   assign wb_dat_o = rdata_q;

   // -------------------------------------------------------------
   // Plain read/write registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         soft_reset_q <= RESET_VALUE;
         pwm_route_q <= RESET_VALUE;
         usb_det_q <= RESET_VALUE;
         drive_a_q <= RESET_VALUE;
         drive_b_q <= RESET_VALUE;
         drive_c_q <= RESET_VALUE;
      end else if (wr) begin
         unique case (wb_adr_i)
            OFS_SOFT_RESET:
               soft_reset_q <= merge(soft_reset_q, MASK_SOFT_RESET);
            OFS_PWM_ROUTE: pwm_route_q <= merge(pwm_route_q, '1);
            OFS_USB_DET: usb_det_q <= merge(usb_det_q, MASK_USB_DET);
            OFS_DRIVE_A: drive_a_q <= merge(drive_a_q, MASK_DRIVE_A);
            OFS_DRIVE_B: drive_b_q <= merge(drive_b_q, MASK_DRIVE_B);
            OFS_DRIVE_C: drive_c_q <= merge(drive_c_q, MASK_DRIVE_C);
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Pin enable register with strap capture
   // -------------------------------------------------------------
   // Static strap pin still crosses into the clock domain
   always_ff @(posedge clk_sys_i) begin
      strap_meta_q <= debug_strap_i;
      strap_sync_q <= strap_meta_q;
   end

   // Strap sampled on the first edge after reset release, not under reset
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         strap_done_q <= 1'b0;
         pin_enable_q <= RESET_VALUE;
      end else begin
         strap_done_q <= 1'b1;
         if (wr && wb_adr_i == OFS_PIN_ENABLE) begin
            pin_enable_q <= merge(pin_enable_q, MASK_PIN_ENABLE);
         end else if (!strap_done_q) begin
            pin_enable_q[PIN_DEBUG] <= strap_sync_q;
         end
      end
   end

   AST_STRAP_LOAD: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      !strap_done_q && !wr
      |=> pin_enable_q[PIN_DEBUG] == $past(strap_sync_q))
      else $error("debug pin enable missed the strap");

   // -------------------------------------------------------------
   // Arbitration control and interrupt boost
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         irq_meta_q <= 2'b00;
         irq_sync_q <= 2'b00;
      end else begin
         irq_meta_q <= {ext_fiq_i, ext_irq_i};
         irq_sync_q <= irq_meta_q;
      end
   end

   assign irq_active = |irq_sync_q;
   assign boost_set = arb_ctrl_q[ARB_BOOST_EN_BIT] && irq_active;
   assign boost_clr = wr && wb_adr_i == OFS_ARB_CTRL && wb_sel_i[0]
                      && wb_dat_i[ARB_BOOST_ACT_BIT];

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         arb_ctrl_q <= RESET_VALUE;
      end else begin
         if (wr && wb_adr_i == OFS_ARB_CTRL) begin
            arb_ctrl_q[ARB_MODE_BIT] <= wb_sel_i[0] ? wb_dat_i[ARB_MODE_BIT]
                                        : arb_ctrl_q[ARB_MODE_BIT];
            arb_ctrl_q[ARB_BOOST_EN_BIT] <= wb_sel_i[0]
               ? wb_dat_i[ARB_BOOST_EN_BIT] : arb_ctrl_q[ARB_BOOST_EN_BIT];
         end
         // Set wins over a same-cycle clear
         if (boost_set) begin
            arb_ctrl_q[ARB_BOOST_ACT_BIT] <= 1'b1;
         end else if (boost_clr) begin
            arb_ctrl_q[ARB_BOOST_ACT_BIT] <= 1'b0;
         end
      end
   end

   // Synchronised interrupt while boosting is enabled
   sequence s_boost_cause;
      arb_ctrl_q[ARB_BOOST_EN_BIT] && irq_active;
   endsequence

   AST_BOOST_SET: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      s_boost_cause |=> arb_ctrl_q[ARB_BOOST_ACT_BIT])
      else $error("boost active not set by interrupt");
   AST_BOOST_NO_SW_SET: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      !arb_ctrl_q[ARB_BOOST_ACT_BIT] && !boost_set
      |=> !arb_ctrl_q[ARB_BOOST_ACT_BIT])
      else $error("boost active set without interrupt");
   AST_BOOST_CLEAR: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      boost_clr && !boost_set |=> !arb_ctrl_q[ARB_BOOST_ACT_BIT])
      else $error("write one did not clear boost active");

   bus_arbiter u_arbiter (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .round_robin_i(arb_ctrl_q[ARB_MODE_BIT]),
      .cpu_boost_i(arb_ctrl_q[ARB_BOOST_ACT_BIT]),
      .req_i(bus_req_i),
      .beat_i(bus_beat_i),
      .grant_o(bus_grant_o)
   );

   AST_FIXED_AUDIO: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      !arb_ctrl_q[ARB_MODE_BIT] && !arb_ctrl_q[ARB_BOOST_ACT_BIT]
      && bus_req_i == 3'b111 && bus_grant_o == 3'b000
      |=> bus_grant_o == 3'b100)
      else $error("fixed mode did not favour audio");

   // -------------------------------------------------------------
   // Peripheral resets, held while the bit reads one
   // -------------------------------------------------------------
   always_comb begin
      spi_slave_block_reset_o = soft_reset_q[RST_SPI_SLAVE];
      adc_reset_o = soft_reset_q[RST_ADC];
      gpio_reset_o = soft_reset_q[RST_GPIO];
      sram_reset_o = soft_reset_q[RST_SRAM];
      audio_unit_reset_o = soft_reset_q[RST_AUDIO];
      usb_device_block_reset_o = soft_reset_q[RST_USB];
      spi_flash_ctrl_reset_o = soft_reset_q[RST_FLASH_SPI];
      i2c_reset_o = soft_reset_q[RST_I2C];
      pwm_reset_o = soft_reset_q[RST_PWM];
      timer_watchdog_reset_o = soft_reset_q[RST_TIMER];
      serial_port1_reset_o = soft_reset_q[RST_SERIAL1];
      serial_port0_reset_o = soft_reset_q[RST_SERIAL0];
   end

   AST_RESET_HOLD: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      wr && wb_adr_i == OFS_SOFT_RESET && wb_sel_i[0] && wb_dat_i[RST_TIMER]
      |=> timer_watchdog_reset_o)
      else $error("timer reset not asserted by write");

   // -------------------------------------------------------------
   // Pin routing decode
   // -------------------------------------------------------------
   for (genvar t = 0; t < 4; t++) begin : g_pwm
      pwm_route_decode u_dec (
         .field_i(pwm_route_q[t*PWM_FIELD_W +: PWM_FIELD_W]),
         .route_o(pwm_route_o[t])
      );
   end

   AST_PWM3_DISABLE: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      pwm_route_q[31:29] > PWM_IN_LAST |-> !pwm_route_o[3].input_valid)
      else $error("timer 3 input not disabled");

   // Unlisted detect codes treated as disabled
   assign det = usb_det_q[3:0];

   always_comb begin
      pin_ctrl_o.analog_pin_enables = pin_enable_q[PIN_ANALOG_LSB +: 8];
      pin_ctrl_o.serial1_modem_pin_enable = pin_enable_q[PIN_SER1_MODEM];
      pin_ctrl_o.serial0_modem_pin_enable = pin_enable_q[PIN_SER0_MODEM];
      pin_ctrl_o.serial1_data_pin_enable = pin_enable_q[PIN_SER1_DATA];
      pin_ctrl_o.serial0_data_pin_enable = pin_enable_q[PIN_SER0_DATA];
      pin_ctrl_o.flash_spi_pin_enable = pin_enable_q[PIN_FLASH_SPI];
      pin_ctrl_o.spi_master_slave_pin_enable = pin_enable_q[PIN_SPI_MS];
      pin_ctrl_o.second_spi_pin_location = pin_enable_q[PIN_SPI2_LSB +: 2];
      pin_ctrl_o.two_wire_pin_location = pin_enable_q[PIN_I2C_LSB +: 2];
      pin_ctrl_o.debug_port_pin_enable = pin_enable_q[PIN_DEBUG];
      pin_ctrl_o.usb_detect_source_select = det;
      pin_ctrl_o.usb_detect_valid = det != 4'h0 && det != USB_DET_GAP
                                    && det != USB_DET_OFF;
   end

   AST_USB_DISABLED: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      (det == 4'h0 || det == USB_DET_GAP || det == USB_DET_OFF)
      |-> !pin_ctrl_o.usb_detect_valid)
      else $error("usb detect not disabled");
   AST_USB_ENABLED: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      det != 4'h0 && det != USB_DET_GAP && det != USB_DET_OFF
      |-> pin_ctrl_o.usb_detect_valid)
      else $error("usb detect wrongly disabled");

   assign port_a_drive_bits_o = drive_a_q[15:0];
   assign port_b_drive_bits_o = drive_b_q[9:0];
   assign port_c_drive_bits_o = drive_c_q[10:0];

   AST_DRIVE_B_RESERVED: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      drive_b_q[31:10] == 22'h0 && drive_c_q[31:11] == 21'h0)
      else $error("reserved drive bits set");

endmodule : system_global_control

`default_nettype wire
